/* core/ctpc_delay_line.sv */
// Fixed-length pulse delay line used for the line sync pipeline.
// Assumes a synchronous active-high reset.
`timescale 1ns/1ps
module ctpc_delay_line #(
  parameter int unsigned DEPTH = 12
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic din,
  output logic dout
);
  logic [DEPTH-1:0] pipe_q;

  // The shift below needs at least two stages
  if (DEPTH < 2) begin : g_bad_depth
    $error("DEPTH must be at least 2");
  end

  // Shift the pulse by one stage per clock
  always_ff @(posedge clk) begin
    if (srst) begin
      pipe_q <= '0;
    end else begin
      pipe_q <= {pipe_q[DEPTH-2:0], din};
    end
  end

  assign dout = pipe_q[DEPTH-1];
endmodule // ctpc_delay_line

/* core/ctpc_device.sv */
// Device end: power-state decode, output drive levels, soft reset, timing
// core reset and horizontal counter resync to line sync.
// Assumes host writes arrive as one-cycle strobes synchronous to clk.
// Operation
// [R1] Power field: 00 normal, 01 standby, 1x shutdown
// [R2] Output enable beats standby; shutdown beats enable
// [R3] Shutdown default: clocks high-Z, data low
// [R4] Enable low: H1 H3 HL RG low, H2 H4 high
// [R5] Host waits 100 us before core reset
// [R6] Reference buffer powerdown defaults set; host clears
// [R7] Host toggles core reset after clock change
// [R8] Line sync falls with or after field sync
// [R9] Host holds syncs idle during start-up writes
// [R10] Counter resets 12 cycles after line sync
// [R11] Line sync captured twice before internal use
// [R12] Counter reset at data edge, 13 or 14 edges
// [R13] Host follows recommended start-up register load
// [R14] Unused toggles programmed zero or maximum
// [R15] Clamp mask at highest position means no mask
// [R16] Soft reset restores defaults and self-clears
// [R17] Writing one to core reset starts core
// [R18] Output enable applies at next sync falling edge
// [R19] Core held idle while core reset bit zero
`timescale 1ns/1ps
module ctpc_device #(
  parameter int unsigned HCNT_MAX = 4095
) (
  input wire logic clk,
  input wire logic srst,
  ctpc_link_if.device link,
  input wire logic data_edge_late,
  input wire logic [ctpc_pkg::HCNT_W-1:0] clamp_start,
  input wire logic [ctpc_pkg::HCNT_W-1:0] clamp_end,
  output logic [3:0] hclk_out,
  output logic [3:0] hclk_oe,
  output logic last_hclk_out,
  output logic last_hclk_oe,
  output logic reset_gate_out,
  output logic reset_gate_oe,
  output logic data_out_zero,
  output logic front_end_on,
  output logic reference_only_on,
  output logic reference_buffer_on,
  output logic timing_core_active,
  output logic [ctpc_pkg::HCNT_W-1:0] hcount,
  output logic hcount_reset,
  output logic black_clamp_pulse
);
  import ctpc_pkg::*;

  logic [27:0] power_q;
  logic soft_reset_hit;
  logic clk_out_en_q;
  logic clk_out_live_q;
  logic tcore_rst_q;
  logic [27:0] pat_count_q;
  logic [27:0] field_count_q;
  logic [27:0] clamp_mask_q;
  logic line_cap_q;
  logic line_prev_q;
  logic field_prev_q;
  logic line_fall;
  logic field_fall;
  logic line_fall_dly;
  logic late_q;
  logic [HCNT_W-1:0] hcount_q;
  logic [1:0] pwr_state;
  logic shutdown;
  logic standby;
  logic wr;
  logic regs_clr;

  // Counter must be able to hold its ceiling
  if (HCNT_MAX >= (1 << HCNT_W)) begin : g_bad_hcnt_max
    $error("HCNT_MAX exceeds counter width");
  end

  assign wr = link.wr_en;
  assign regs_clr = srst | soft_reset_hit; // [R16]
  assign pwr_state = power_q[PWR_STATE_LSB +: 2];
  // Decode of the two-bit power field
  assign shutdown = pwr_state[1]; // [R1]
  assign standby = (pwr_state == PWR_REF_STANDBY); // [R1]

  // Power register: shutdown and buffer powerdown are the reset state
  always_ff @(posedge clk) begin
    if (regs_clr) begin
      power_q <= POWER_RESET; // [R3] [R6]
    end else if (wr && link.wr_addr == REG_POWER) begin
      power_q <= link.wr_data;
    end
  end

  // Soft reset acts at the edge that takes the write and leaves no bit set,
  // so a write right behind it in a back-to-back burst is kept
  assign soft_reset_hit = wr && link.wr_addr == REG_SOFT_RESET && link.wr_data[0]; // [R16]

  // Control registers; a soft reset clears them with the rest
  always_ff @(posedge clk) begin
    if (regs_clr) begin
      clk_out_en_q <= 1'b0;
      tcore_rst_q <= 1'b0;
      pat_count_q <= ZERO_RESET;
      field_count_q <= ZERO_RESET;
      clamp_mask_q <= SCP_MAX;
    end else if (wr) begin
      if (link.wr_addr == REG_CLK_OUT_EN) clk_out_en_q <= link.wr_data[0];
      if (link.wr_addr == REG_TCORE_RST) tcore_rst_q <= link.wr_data[0]; // [R17]
      if (link.wr_addr == REG_PAT_COUNT) pat_count_q <= link.wr_data;
      if (link.wr_addr == REG_FIELD_COUNT) field_count_q <= link.wr_data;
      if (link.wr_addr == REG_CLAMP_MASK) clamp_mask_q <= link.wr_data;
    end
  end

  // Sync edge detect; line sync taken on the rising clock edge first
  always_ff @(posedge clk) begin
    if (srst) begin
      line_cap_q <= 1'b1;
      line_prev_q <= 1'b1;
      field_prev_q <= 1'b1;
    end else begin
      line_cap_q <= link.line_sync_n; // [R11]
      line_prev_q <= line_cap_q;
      field_prev_q <= link.field_sync_n;
    end
  end

  assign line_fall = line_prev_q & ~line_cap_q; // [R11]
  assign field_fall = field_prev_q & ~link.field_sync_n;

  // Enable only goes live at a line or field sync falling edge, so a line is never cut
  always_ff @(posedge clk) begin
    if (regs_clr) begin
      clk_out_live_q <= 1'b0;
    end else if (field_fall || line_fall) begin
      clk_out_live_q <= clk_out_en_q; // [R18]
    end
  end

  // Second capture plus pipeline; the late data edge adds one cycle
  ctpc_delay_line #(
    .DEPTH(HCNT_RESET_CYC - 1)
  ) u_line_pipe (
    .clk(clk),
    .srst(srst),
    .din(line_fall),
    .dout(line_fall_dly)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      late_q <= 1'b0;
    end else begin
      late_q <= line_fall_dly;
    end
  end

  // 12 cycles nominal (13 edges), 13 cycles when data edge is late
  assign hcount_reset = data_edge_late ? late_q : line_fall_dly; // [R10] [R12]

  // Horizontal counter: held while the core is off or in reset
  always_ff @(posedge clk) begin
    if (srst || !tcore_rst_q || shutdown) begin
      hcount_q <= '0; // [R19]
    end else if (hcount_reset) begin
      hcount_q <= '0; // [R10]
    end else if (hcount_q != HCNT_W'(HCNT_MAX)) begin
      hcount_q <= hcount_q + 1'b1;
    end
  end

  assign hcount = hcount_q;
  assign timing_core_active = tcore_rst_q && !shutdown; // [R19] [R3]

  // Clamp pulse; a mask at the top position disables masking
  always_ff @(posedge clk) begin
    if (srst || !timing_core_active) begin
      black_clamp_pulse <= 1'b0;
    end else begin
      black_clamp_pulse <= (hcount_q >= clamp_start) && (hcount_q < clamp_end)
        && ((clamp_mask_q == SCP_MAX) // [R15]
        || (hcount_q < clamp_mask_q[HCNT_W-1:0]));
    end
  end

  // Output drive: shutdown first, then enable over standby
  always_comb begin
    hclk_oe = 4'hF;
    last_hclk_oe = 1'b1;
    reset_gate_oe = 1'b1;
    data_out_zero = 1'b1;
    hclk_out = 4'hA; // H2 and H4 high, H1 and H3 low [R4]
    last_hclk_out = 1'b0;
    reset_gate_out = 1'b0;
    if (shutdown) begin
      hclk_oe = 4'h0; // [R2] [R3]
      last_hclk_oe = 1'b0;
      reset_gate_oe = 1'b0;
      hclk_out = 4'h0;
    end else if (clk_out_live_q && timing_core_active) begin
      data_out_zero = 1'b0; // [R2]
      hclk_out = {~hcount_q[0], hcount_q[0], ~hcount_q[0], hcount_q[0]};
      last_hclk_out = hcount_q[0];
      reset_gate_out = ~hcount_q[0];
    end
  end

  // Front end power; standby keeps only reference buffers
  assign front_end_on = (pwr_state == PWR_NORMAL); // [R1]
  assign reference_only_on = standby; // [R1]
  assign reference_buffer_on = !shutdown && !power_q[REFBUF_PD_BIT]; // [R6]
endmodule // ctpc_device

/* core/ctpc_host.sv */
// Host end: runs the start-up register load, settle wait, then sync pulses.
// Assumes the device end shares clk.
`timescale 1ns/1ps
module ctpc_host #(
  parameter int unsigned SETTLE_CYCLES = ctpc_pkg::SETTLE_CYC,
  parameter int unsigned LINE_LEN = 64
) (
  input wire logic clk,
  input wire logic srst,
  ctpc_link_if.host link,
  input wire logic start,
  input wire logic clock_changed,
  output logic done
);
  import ctpc_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LOAD = 6'h02,
    ST_WAIT = 6'h04,
    ST_CORE = 6'h08,
    ST_RUN = 6'h10,
    ST_RECL = 6'h20
  } ctpc_host_state_e;

  ctpc_host_state_e state_q;
  logic [3:0] step_q;
  logic [31:0] wait_q;
  logic [31:0] line_q;

  // Sync pulse is two cycles long, so a line needs room around it
  if (SETTLE_CYCLES < 1 || LINE_LEN < 4) begin : g_bad_params
    $error("Bad host parameters");
  end

  // Start-up load table, ending with the power field set to normal
  function automatic logic [39:0] load_entry(input logic [3:0] idx);
    unique case (idx)
      4'h0: load_entry = {REG_SOFT_RESET, ONE_RESET}; // [R13]
      4'h1: load_entry = {REG_PAT_COUNT, ONE_RESET};
      4'h2: load_entry = {REG_FIELD_COUNT, ONE_RESET};
      4'h3: load_entry = {REG_CLAMP_MASK, SCP_MAX}; // [R14]
      4'h4: load_entry = {REG_TCORE_RST, ZERO_RESET};
      default: load_entry = {REG_POWER, ZERO_RESET}; // [R5] [R6]
    endcase
  endfunction

  // Sequencer; core reset after settle at start-up, straight after the clear on a clock change; enable write last
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      step_q <= 4'h0;
      wait_q <= '0;
      link.wr_en <= 1'b0;
      link.wr_addr <= 12'h000;
      link.wr_data <= ZERO_RESET;
    end else begin
      link.wr_en <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (start) state_q <= ST_LOAD;
          step_q <= 4'h0;
        end
        ST_LOAD: begin
          link.wr_en <= 1'b1;
          {link.wr_addr, link.wr_data} <= load_entry(step_q);
          step_q <= step_q + 1'b1;
          wait_q <= '0;
          if (step_q == 4'h5) state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          wait_q <= wait_q + 1'b1;
          if (wait_q >= SETTLE_CYCLES) state_q <= ST_CORE; // [R5]
        end
        ST_CORE: begin
          link.wr_en <= 1'b1;
          link.wr_addr <= step_q[0] ? REG_CLK_OUT_EN : REG_TCORE_RST;
          link.wr_data <= ONE_RESET; // [R7] [R13]
          step_q <= step_q + 1'b1;
          if (step_q[0]) state_q <= ST_RUN;
        end
        ST_RUN: begin
          if (clock_changed) state_q <= ST_RECL;
        end
        ST_RECL: begin
          link.wr_en <= 1'b1;
          link.wr_addr <= REG_TCORE_RST;
          link.wr_data <= ZERO_RESET; // [R7]
          step_q <= 4'h6;
          state_q <= ST_CORE;
        end
      endcase
    end
  end

  // Syncs idle until running; both fall together at line start
  always_ff @(posedge clk) begin
    if (srst || state_q != ST_RUN) begin
      line_q <= '0;
      link.line_sync_n <= 1'b1; // [R9]
      link.field_sync_n <= 1'b1;
    end else begin
      line_q <= (line_q == LINE_LEN - 1) ? '0 : line_q + 1'b1;
      link.line_sync_n <= (line_q >= 2); // [R8]
      link.field_sync_n <= (line_q >= 2);
    end
  end

  assign done = (state_q == ST_RUN);
endmodule // ctpc_host

/* core/ctpc_link_if.sv */
// Link between host end and device end: register write strobe and syncs.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface ctpc_link_if;
  logic wr_en;
  logic [11:0] wr_addr;
  logic [27:0] wr_data;
  logic field_sync_n;
  logic line_sync_n;
  modport device (input wr_en, input wr_addr, input wr_data, input field_sync_n,
    input line_sync_n);
  modport host (output wr_en, output wr_addr, output wr_data, output field_sync_n,
    output line_sync_n);
endinterface

/* core/ctpc_pkg.sv */
// Package for the timing and power control block: register offsets, field
// positions, reset values and cycle counts shared by both ends.
// Assumes a single 20 MHz clock shared by device and host ends.
package ctpc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 28;
  // Register offsets
  localparam logic [11:0] REG_POWER = 12'h000;
  localparam logic [11:0] REG_SOFT_RESET = 12'h010;
  localparam logic [11:0] REG_CLK_OUT_EN = 12'h011;
  localparam logic [11:0] REG_TCORE_RST = 12'h014;
  localparam logic [11:0] REG_PAT_COUNT = 12'h028;
  localparam logic [11:0] REG_FIELD_COUNT = 12'h02A;
  localparam logic [11:0] REG_CLAMP_MASK = 12'h819;
  // Field positions and reset values
  localparam int unsigned PWR_STATE_LSB = 0;
  localparam int unsigned REFBUF_PD_BIT = 2;
  localparam logic [27:0] POWER_RESET = 28'h0000007;
  localparam logic [27:0] ZERO_RESET = 28'h0000000;
  localparam logic [27:0] ONE_RESET = 28'h0000001;
  localparam logic [27:0] SCP_MAX = 28'h1000800;
  localparam logic [27:0] TOGGLE_MAX = 28'h3FFFFFF;
  // Power states
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_REF_STANDBY = 2'h1;
  // Line sync pipeline: first capture plus internal delay to counter reset
  localparam int unsigned HCNT_RESET_CYC = 12;
  localparam int unsigned HCNT_W = 13;
  // Shutdown exit settle time before timing core reset
  localparam int unsigned SETTLE_US = 100;
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_MHZ;
endpackage

/* tb/ctpc_props.sv */
// Checker for the link: write order, settle wait and sync framing.
// Assumes the shared clock and the synchronous active-high reset.
`timescale 1ns/1ps
module ctpc_props #(
  parameter int unsigned SETTLE = 20
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [11:0] wr_addr,
  input wire logic [27:0] wr_data,
  input wire logic field_sync_n,
  input wire logic line_sync_n
);
  import ctpc_pkg::*;
  logic [15:0] settle_q;
  logic [2:0] n_wr_q;
  logic core_zero_q, outs_on_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Age of the last power write; saturates so long runs never wrap
  always_ff @(posedge clk) begin
    if (srst || (wr_en && wr_addr == REG_POWER)) settle_q <= 16'h0000;
    else if (settle_q != 16'hFFFF) settle_q <= settle_q + 16'h0001;
  end
  // Writes since reset, saturating
  always_ff @(posedge clk) begin
    if (srst) n_wr_q <= 3'h0;
    else if (wr_en && n_wr_q != 3'h7) n_wr_q <= n_wr_q + 3'h1;
  end
  // Core reset bit last written as zero
  always_ff @(posedge clk) begin
    if (srst) core_zero_q <= 1'b0;
    else if (wr_en && wr_addr == REG_TCORE_RST) core_zero_q <= !wr_data[0];
  end
  // Output enable write closes the start-up load
  always_ff @(posedge clk) begin
    if (srst) outs_on_q <= 1'b0;
    else if (wr_en && wr_addr == REG_CLK_OUT_EN && wr_data[0]) outs_on_q <= 1'b1;
  end
  a_line_after_field: assert property (
    $fell(line_sync_n) |-> !field_sync_n) else $error("line sync fell first");
  a_field_not_late: assert property (
    $fell(field_sync_n) |-> $past(line_sync_n)) else $error("field sync fell late");
  a_start_sync_idle: assert property (
    wr_en && !outs_on_q |-> field_sync_n && line_sync_n) else $error("sync during load");
  a_settle_wait: assert property (
    wr_en && wr_addr == REG_TCORE_RST && wr_data[0] |-> settle_q + 16'h0001 >= SETTLE)
    else $error("core reset too early");
  a_core_toggle: assert property (
    wr_en && wr_addr == REG_TCORE_RST && wr_data[0] |-> core_zero_q)
    else $error("core reset set without clear");
  a_first_soft_reset: assert property (
    wr_en && n_wr_q == 3'h0 |-> wr_addr == REG_SOFT_RESET && wr_data == ONE_RESET)
    else $error("first write not soft reset");
  a_start_burst: assert property (
    wr_en && n_wr_q == 3'h0 |=> wr_en [*5]) else $error("start burst broken");
  a_pat_second: assert property (
    wr_en && n_wr_q == 3'h1 |-> wr_addr == REG_PAT_COUNT && wr_data == ONE_RESET)
    else $error("second write wrong");
  a_field_third: assert property (
    wr_en && n_wr_q == 3'h2 |-> wr_addr == REG_FIELD_COUNT && wr_data == ONE_RESET)
    else $error("third write wrong");
  a_power_normal: assert property (
    wr_en && wr_addr == REG_POWER |-> wr_data[2:0] == 3'h0) else $error("power not normal");
  a_enable_follows: assert property (
    wr_en && wr_addr == REG_TCORE_RST && wr_data[0]
    |-> ##[1:8] (wr_en && wr_addr == REG_CLK_OUT_EN)) else $error("no enable write");
endmodule // ctpc_props

/* tb/tb.sv */
// Bench: host end drives device end over the link; bench watches both.
// Assumes a 50 ns clock and a short settle count for simulation.
`timescale 1ns/1ps
module tb;
  import ctpc_pkg::*;
  localparam int unsigned SETTLE = 20;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic start = 1'b0;
  logic clock_changed = 1'b0;
  logic data_edge_late = 1'b0;
  logic [HCNT_W-1:0] clamp_start = 13'h0004;
  logic [HCNT_W-1:0] clamp_end = 13'h0010;
  logic done, last_hclk_out, last_hclk_oe, reset_gate_out, reset_gate_oe, data_out_zero;
  logic front_end_on, reference_only_on, reference_buffer_on, timing_core_active;
  logic hcount_reset, black_clamp_pulse;
  logic [3:0] hclk_out, hclk_oe;
  logic [HCNT_W-1:0] hcount;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  ctpc_link_if i_ctpc_link_if ();
  ctpc_host #(.SETTLE_CYCLES(SETTLE), .LINE_LEN(64)) i_ctpc_host (.clk(clk), .srst(srst),
    .link(i_ctpc_link_if), .start(start), .clock_changed(clock_changed), .done(done));
  ctpc_device i_ctpc_device (.clk(clk), .srst(srst), .link(i_ctpc_link_if),
    .data_edge_late(data_edge_late), .clamp_start(clamp_start), .clamp_end(clamp_end),
    .hclk_out(hclk_out), .hclk_oe(hclk_oe), .last_hclk_out(last_hclk_out),
    .last_hclk_oe(last_hclk_oe), .reset_gate_out(reset_gate_out),
    .reset_gate_oe(reset_gate_oe), .data_out_zero(data_out_zero),
    .front_end_on(front_end_on), .reference_only_on(reference_only_on),
    .reference_buffer_on(reference_buffer_on), .timing_core_active(timing_core_active),
    .hcount(hcount), .hcount_reset(hcount_reset), .black_clamp_pulse(black_clamp_pulse));
  ctpc_props #(.SETTLE(SETTLE)) i_ctpc_props (.clk(clk), .srst(srst),
    .wr_en(i_ctpc_link_if.wr_en), .wr_addr(i_ctpc_link_if.wr_addr),
    .wr_data(i_ctpc_link_if.wr_data), .field_sync_n(i_ctpc_link_if.field_sync_n),
    .line_sync_n(i_ctpc_link_if.line_sync_n));
  // Clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      results();
    end
  end
  task automatic results();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs move a fixed 1 ns after the rising edge
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // Waits for one host write and lets the edge that takes it pass
  task automatic wait_wr(input logic [11:0] addr, input logic [27:0] data);
    int n;
    n = 0;
    while (n < 3000 && !(i_ctpc_link_if.wr_en === 1'b1 && i_ctpc_link_if.wr_addr === addr
      && i_ctpc_link_if.wr_data === data)) begin
      step();
      n++;
    end
    check(n < 3000, 1'b1);
    step();
  endtask
  task automatic t_reset_state();
    check({hclk_oe, last_hclk_oe, reset_gate_oe}, 6'h00);
    check({data_out_zero, front_end_on, timing_core_active}, 3'h4);
    check(reference_buffer_on, 1'b0);
    check(hcount, 13'h0000);
    check({i_ctpc_link_if.field_sync_n, i_ctpc_link_if.line_sync_n, done}, 3'h6);
  endtask
  // Levels before the enable reaches the outputs, which needs a sync fall
  task automatic t_startup();
    start = 1'b1;
    step();
    start = 1'b0;
    wait_wr(REG_TCORE_RST, ZERO_RESET);
    check(timing_core_active, 1'b0);
    wait_wr(REG_POWER, ZERO_RESET);
    check({front_end_on, reference_buffer_on, reference_only_on}, 3'h6);
    check(timing_core_active, 1'b0);
    wait_wr(REG_TCORE_RST, ONE_RESET);
    check(timing_core_active, 1'b1);
    wait_wr(REG_CLK_OUT_EN, ONE_RESET);
    check({hclk_out, hclk_oe}, 8'hAF);
    check({last_hclk_out, last_hclk_oe, reset_gate_out, reset_gate_oe, data_out_zero},
      5'h0B);
    check(done, 1'b1);
  endtask
  // Counted from the edge that drives the fall: pulse 12 cycles on, 13 when late
  task automatic t_line_resync(input logic late);
    int n;
    logic [3:0] prev;
    n = 0;
    data_edge_late = late;
    repeat (200) if (i_ctpc_link_if.line_sync_n !== 1'b1) step();
    repeat (200) if (i_ctpc_link_if.line_sync_n !== 1'b0) step();
    while (hcount_reset !== 1'b1 && n < 40) begin
      step();
      n++;
    end
    check(n, 12 + late);
    step();
    check(hcount, 13'h0000);
    prev = hclk_out;
    step();
    check(hclk_out !== prev, 1'b1);
    check(hclk_oe, 4'hF);
    check(black_clamp_pulse, 1'b0);
    repeat (5) step();
    check(black_clamp_pulse, 1'b1);
  endtask
  task automatic t_clock_change();
    clock_changed = 1'b1;
    step();
    clock_changed = 1'b0;
    wait_wr(REG_TCORE_RST, ZERO_RESET);
    check(timing_core_active, 1'b0);
    wait_wr(REG_TCORE_RST, ONE_RESET);
    check(hcount, 13'h0000);
    check(timing_core_active, 1'b1);
  endtask
  // A second reset in mid-run must restore the shutdown defaults, and they
  // must still stand two edges after release with the host left idle
  task automatic t_mid_reset();
    srst = 1'b1;
    repeat (8) step();
    srst = 1'b0;
    t_reset_state();
    repeat (2) step();
    t_reset_state();
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 srst = 1'b0;
    t_reset_state();
    t_startup();
    t_line_resync(1'b0);
    t_clock_change();
    t_line_resync(1'b1);
    t_mid_reset();
    results();
  end
endmodule // tb
